// file: src/fns_pkg.sv
package fns_pkg;
   // ---------------------------------------------------------------
   // register bus map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_WORD = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h4;
   localparam logic [3:0] ADDR_MOD  = 4'h8;

   // ---------------------------------------------------------------
   // control bit codes in the two lowest bits of each word
   // ---------------------------------------------------------------
   localparam logic [1:0] SEL_FB  = 2'h0;
   localparam logic [1:0] SEL_REF = 2'h1;
   localparam logic [1:0] SEL_CTL = 2'h2;
   localparam logic [1:0] SEL_NS  = 2'h3;

   // ---------------------------------------------------------------
   // word layouts
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        fast_lock;
      logic [8:0]  int_val;
      logic [11:0] fractional_numerator;
      logic [1:0]  sel;
   } fns_fb_s;

   typedef struct packed {
      logic        load_timer;
      logic [2:0]  mux_sel;
      logic        rsv;
      logic        prescaler;
      logic [3:0]  ref_ratio;
      logic [11:0] fractional_modulus;
      logic [1:0]  sel;
   } fns_ref_s;

   typedef struct packed {
      logic [3:0]  rsv;
      logic        doubler;
      logic [3:0]  cp_current;
      logic        polarity;
      logic        lock_precision_select;
      logic        power_down;
      logic        cp_tristate;
      logic        counter_reset;
      logic [1:0]  sel;
   } fns_ctl_s;

   // noise and spur mode bits inside the 16-bit word
   localparam int         NS_MODE_LO = 2;
   localparam int         NS_MODE_HI = 10;
   localparam logic [1:0] NS_LOWEST_SPUR  = 2'h0;
   localparam logic [1:0] NS_LOWEST_NOISE = 2'h1;
   localparam logic [1:0] NS_LOW_NS       = 2'h3;

   // ---------------------------------------------------------------
   // multiplexed output selections
   // ---------------------------------------------------------------
   localparam logic [2:0] MUX_LOW   = 3'h0;
   localparam logic [2:0] MUX_HIGH  = 3'h1;
   localparam logic [2:0] MUX_GND   = 3'h2;
   localparam logic [2:0] MUX_RDIV  = 3'h3;
   localparam logic [2:0] MUX_NDIV  = 3'h4;
   localparam logic [2:0] MUX_ALOCK = 3'h5;
   localparam logic [2:0] MUX_FLSW  = 3'h6;
   localparam logic [2:0] MUX_DLOCK = 3'h7;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int         CLK_PS      = 8000;
   localparam int         GOOD_NS     = 15;
   localparam int         BAD_NS      = 30;
   localparam logic [7:0] GOOD_CYC    = 8'((GOOD_NS * 1000) / CLK_PS);
   localparam logic [7:0] BAD_CYC     = 8'((BAD_NS * 1000) / CLK_PS);
   localparam logic [5:0] LOCK_RUN_LO = 6'h18;
   localparam logic [5:0] LOCK_RUN_HI = 6'h28;

   // reset values
   localparam fns_fb_s    FB_RST  = '0;
   localparam fns_ref_s   REF_RST = '0;
   localparam fns_ctl_s   CTL_RST = '0;
   localparam logic [15:0] NS_RST = 16'h0000;
endpackage : fns_pkg

// file: src/fns_regctl.sv
// Operation
// - control bits 00 select feedback word
// - control bits 01 select reference word
// - control bits 11 select noise word
// - nine-bit integer divide value held
// - fast lock boosts pump until timer expires
// - load bit steers field to timer/modulus
// - timer counts down at PFD rate
// - three-bit field selects multiplexed output
// - lock sets on good run, drops
// - precision bit picks 24 or 40
// - reference ratio 1 to 15 only
// - new modulus waits for feedback write
// - counter reset bit holds counters
// - tristate bit floats charge pump
// - power-down keeps registers, stops loop
// - polarity bit sets detector sense
// - four-bit pump current setting
// - doubler makes both reference edges active
// - noise mode sets dither, pump bias
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module fns_regctl (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        reference_input_i,
   input  wire logic        rf_feedback_input_i,
   output logic             multiplexed_output_o,
   output logic             lock_detect_o,
   output logic             cp_boost_o,
   output logic             cp_tristate_o,
   output logic [3:0]       cp_current_o,
   output logic             cp_low_noise_o,
   output logic             pd_polarity_o,
   output logic             counter_reset_o,
   output logic             power_down_o,
   output logic             doubler_en_o,
   output logic             dither_en_o,
   output logic             prescaler_o,
   output logic [3:0]       ref_ratio_o,
   output logic [8:0]       int_o,
   output logic [11:0]      fractional_numerator_o,
   output logic [11:0]      mod_o
);
   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   fns_pkg::fns_fb_s  fb_r;
   fns_pkg::fns_ref_s ref_r;
   fns_pkg::fns_ctl_s ctl_r;
   logic [15:0] ns_r;
   logic [11:0] mod_pend_r;
   logic [11:0] mod_act_r;
   logic [11:0] fl_cnt_r;
   logic        lock_r;
   logic        wait_r;
   logic [31:0] rdata_r;
   logic        acc;
   logic        wr_word;
   logic [23:0] word;
   logic [1:0]  sel;
   logic        hold;

   // a request is answered on the edge after it is seen; the write lands on the
   // edge at which the master samples waitrequest low
   assign acc     = (avs_read_i | avs_write_i) & wait_r;
   assign word    = avs_writedata_i[23:0];
   assign sel     = word[1:0];
   assign wr_word = avs_write_i & ~wait_r & (avs_address_i == fns_pkg::ADDR_WORD)
                    & (&avs_byteenable_i[2:0]);

   // waitrequest drops for exactly one cycle per request
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wait_r <= 1'b1;
      end else begin
         wait_r <= ~acc;
      end
   end

   // read data captured as the answer is given
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_r <= 32'h00000000;
      end else if (acc && avs_read_i) begin
         unique case (avs_address_i)
            fns_pkg::ADDR_STAT:
               rdata_r <= {26'h0000000, doubler_en_o, dither_en_o,
                           counter_reset_o, power_down_o, cp_boost_o, lock_r};
            fns_pkg::ADDR_MOD:
               rdata_r <= {4'h0, mod_pend_r, 4'h0, mod_act_r};
            default:
               rdata_r <= 32'h00000000; // unmapped and write-only
         endcase
      end
   end

   assign avs_readdata_o    = rdata_r;
   assign avs_waitrequest_o = wait_r;

   // ---------------------------------------------------------------
   // word routing by control bits
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         fb_r <= fns_pkg::FB_RST;
      end else if (wr_word && sel == fns_pkg::SEL_FB) begin
         fb_r <= word;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ref_r <= fns_pkg::REF_RST;
      end else if (wr_word && sel == fns_pkg::SEL_REF) begin
         ref_r <= word;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctl_r <= fns_pkg::CTL_RST;
      end else if (wr_word && sel == fns_pkg::SEL_CTL) begin
         ctl_r <= word[15:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ns_r <= fns_pkg::NS_RST;
      end else if (wr_word && sel == fns_pkg::SEL_NS) begin
         ns_r <= word[15:0];
      end
   end

   // modulus double buffer: staged by reference word, used on feedback word
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         mod_pend_r <= 12'h000;
         mod_act_r  <= 12'h000;
      end else begin
         if (wr_word && sel == fns_pkg::SEL_REF && !word[23]) begin
            mod_pend_r <= word[13:2];
         end
         if (wr_word && sel == fns_pkg::SEL_FB) begin
            mod_act_r <= mod_pend_r;
         end
      end
   end

   // ---------------------------------------------------------------
   // link input sampling
   // ---------------------------------------------------------------
   logic [2:0] ref_s_r;
   logic [2:0] fb_s_r;

   // two flops per pin, the third only feeds edge detection
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ref_s_r <= 3'h0;
         fb_s_r  <= 3'h0;
      end else begin
         ref_s_r <= {ref_s_r[1:0], reference_input_i};
         fb_s_r  <= {fb_s_r[1:0], rf_feedback_input_i};
      end
   end

   logic ref_edge;
   logic fb_edge;
   // reference falling edge only, or both edges with the doubler on; feedback rising edge only
   assign ref_edge = ctl_r.doubler ? (ref_s_r[1] ^ ref_s_r[2])
                                   : (~ref_s_r[1] & ref_s_r[2]);
   assign fb_edge  = fb_s_r[1] & ~fb_s_r[2];
   assign hold     = ctl_r.counter_reset | ctl_r.power_down;

   // ---------------------------------------------------------------
   // reference divider
   // ---------------------------------------------------------------
   logic [3:0] rcnt_r;
   logic       pfd_tick_r;
   logic [3:0] ratio;

   // ratio 0 is illegal and behaves as 1
   assign ratio = (ref_r.ref_ratio == 4'h0) ? 4'h1 : ref_r.ref_ratio;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rcnt_r     <= 4'h0;
         pfd_tick_r <= 1'b0;
      end else if (hold) begin
         rcnt_r     <= 4'h0;
         pfd_tick_r <= 1'b0;
      end else if (ref_edge) begin
         if (rcnt_r + 4'h1 >= ratio) begin
            rcnt_r     <= 4'h0;
            pfd_tick_r <= 1'b1;
         end else begin
            rcnt_r     <= rcnt_r + 4'h1;
            pfd_tick_r <= 1'b0;
         end
      end else begin
         pfd_tick_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // fast-lock timer
   // ---------------------------------------------------------------
   logic [11:0] fl_time_r;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         fl_time_r <= 12'h000;
      end else if (wr_word && sel == fns_pkg::SEL_REF && word[23]) begin
         fl_time_r <= word[13:2];
      end
   end

   // loaded on a fast-lock feedback write, counts PFD periods
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         fl_cnt_r <= 12'h000;
      end else if (ctl_r.power_down) begin
         fl_cnt_r <= 12'h000;
      end else if (wr_word && sel == fns_pkg::SEL_FB && word[23]) begin
         fl_cnt_r <= fl_time_r;
      end else if (pfd_tick_r && fl_cnt_r != 12'h000) begin
         fl_cnt_r <= fl_cnt_r - 12'h001;
      end
   end

   // ---------------------------------------------------------------
   // digital lock detect
   // ---------------------------------------------------------------
   logic [7:0] since_ref_r;
   logic [7:0] since_fb_r;
   logic [7:0] lag_r;
   logic [5:0] run_r;
   logic [7:0] err;
   logic [5:0] need;
   logic       good;
   logic       bad;

   // saturating distance counters from each edge
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         since_ref_r <= 8'hFF;
         since_fb_r  <= 8'hFF;
         lag_r       <= 8'hFF;
      end else begin
         since_ref_r <= pfd_tick_r ? 8'h00
                      : (since_ref_r == 8'hFF ? 8'hFF : since_ref_r + 8'h01);
         since_fb_r  <= fb_edge ? 8'h00
                      : (since_fb_r == 8'hFF ? 8'hFF : since_fb_r + 8'h01);
         if (fb_edge) begin
            lag_r <= since_ref_r;
         end
      end
   end

   // error taken as the nearer of a leading or lagging feedback edge
   assign err  = (since_fb_r < lag_r) ? since_fb_r : lag_r;
   assign good = err <= fns_pkg::GOOD_CYC;
   assign bad  = err > fns_pkg::BAD_CYC;
   assign need = ctl_r.lock_precision_select ? fns_pkg::LOCK_RUN_HI
                                             : fns_pkg::LOCK_RUN_LO;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         run_r  <= 6'h00;
         lock_r <= 1'b0;
      end else if (hold || (wr_word && sel == fns_pkg::SEL_FB)) begin
         run_r  <= 6'h00;
         lock_r <= 1'b0;
      end else if (pfd_tick_r) begin
         if (!good) begin
            run_r <= 6'h00;
         end else if (run_r + 6'h01 >= need) begin
            lock_r <= 1'b1;
         end else begin
            run_r <= run_r + 6'h01;
         end
         if (bad) begin
            lock_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // output flops
   // ---------------------------------------------------------------
   logic [1:0] ns_mode;
   logic       fl_on;
   assign ns_mode = {ns_r[fns_pkg::NS_MODE_HI], ns_r[fns_pkg::NS_MODE_LO]};
   assign fl_on   = fl_cnt_r != 12'h000;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         lock_detect_o   <= 1'b0;
         cp_boost_o      <= 1'b0;
         cp_tristate_o   <= 1'b0;
         cp_current_o    <= 4'h0;
         cp_low_noise_o  <= 1'b0;
         pd_polarity_o   <= 1'b0;
         counter_reset_o <= 1'b0;
         power_down_o    <= 1'b0;
         doubler_en_o    <= 1'b0;
         dither_en_o     <= 1'b1;
         prescaler_o     <= 1'b0;
         ref_ratio_o     <= 4'h0;
         int_o           <= 9'h000;
         fractional_numerator_o          <= 12'h000;
         mod_o           <= 12'h000;
      end else begin
         lock_detect_o   <= lock_r;
         cp_boost_o      <= fl_on;
         cp_tristate_o   <= ctl_r.cp_tristate | ctl_r.power_down;
         cp_current_o    <= ctl_r.cp_current;
         cp_low_noise_o  <= ns_mode == fns_pkg::NS_LOWEST_NOISE;
         pd_polarity_o   <= ctl_r.polarity;
         counter_reset_o <= hold;
         power_down_o    <= ctl_r.power_down;
         doubler_en_o    <= ctl_r.doubler;
         dither_en_o     <= ns_mode == fns_pkg::NS_LOWEST_SPUR;
         prescaler_o     <= ref_r.prescaler;
         ref_ratio_o     <= ratio;
         int_o           <= fb_r.int_val;
         fractional_numerator_o          <= fb_r.fractional_numerator;
         mod_o           <= mod_act_r;
      end
   end

   // multiplexed output; fast-lock switch pulls low while active
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         multiplexed_output_o <= 1'b0;
      end else begin
         unique case (ref_r.mux_sel)
            fns_pkg::MUX_LOW:   multiplexed_output_o <= 1'b0;
            fns_pkg::MUX_HIGH:  multiplexed_output_o <= 1'b1;
            fns_pkg::MUX_GND:   multiplexed_output_o <= 1'b0;
            fns_pkg::MUX_RDIV:  multiplexed_output_o <= pfd_tick_r;
            fns_pkg::MUX_NDIV:  multiplexed_output_o <= fb_edge;
            fns_pkg::MUX_ALOCK: multiplexed_output_o <= lock_r & good;
            fns_pkg::MUX_FLSW:  multiplexed_output_o <= ~fl_on;
            fns_pkg::MUX_DLOCK: multiplexed_output_o <= lock_r;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   a_route_fb: assert property (wr_word && sel == fns_pkg::SEL_FB
      |=> ##1 int_o == $past(word[22:14], 2)) else $error("integer not routed");
   a_route_ctl: assert property (wr_word && sel == fns_pkg::SEL_CTL
      |=> ##1 cp_current_o == $past(word[10:7], 2)) else $error("control not routed");
   a_route_ns: assert property (wr_word && sel == fns_pkg::SEL_NS
      |=> ##1 dither_en_o == ($past(word[10], 2) == 1'b0 && $past(word[2], 2) == 1'b0))
      else $error("noise word not routed");
   a_mod_wait: assert property (wr_word && sel == fns_pkg::SEL_REF
      |=> ##1 $stable(mod_o)) else $error("modulus used before feedback write");
   a_mod_load: assert property (wr_word && sel == fns_pkg::SEL_FB
      |=> ##1 mod_o == $past(mod_pend_r, 2)) else $error("modulus not loaded");
   a_fl_start: assert property (wr_word && sel == fns_pkg::SEL_FB && word[23]
      && fl_time_r != 12'h000 && !ctl_r.power_down |=> ##1 cp_boost_o)
      else $error("fast lock did not start");
   a_fl_tick: assert property (pfd_tick_r && fl_on && !wr_word && !ctl_r.power_down
      |=> fl_cnt_r == $past(fl_cnt_r) - 12'h001) else $error("timer missed a tick");
   a_lock_need: assert property ($rose(lock_r) |-> $past(run_r) + 6'h01 >= need)
      else $error("lock set too early");
   a_lock_drop: assert property (pfd_tick_r && bad && !hold && !wr_word
      |=> !lock_r ##1 !lock_detect_o) else $error("lock held on large error");
   a_pd_float: assert property (ctl_r.power_down |=> cp_tristate_o && counter_reset_o
      && !lock_r) else $error("power-down effects missing");
   a_tristate: assert property (ctl_r.cp_tristate |=> cp_tristate_o)
      else $error("charge pump not floated");

   c_lock: cover property ($rose(lock_detect_o));
   c_fast: cover property ($rose(cp_boost_o) ##[1:1000] $fell(cp_boost_o));
   c_modswap: cover property (wr_word && sel == fns_pkg::SEL_FB && mod_pend_r != mod_act_r);
endmodule : fns_regctl
`default_nettype wire

// file: testbench/fns_loop_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// reference oscillator and divided feedback of the loop
// ---------------------------------------------------------------
module fns_loop_model (
   input  wire logic slip_i,
   output logic      ref_o,
   output logic      fb_o
);
   // free running reference, 160 ns period
   initial begin
      ref_o = 1'b1;
      fb_o  = 1'b0;
      forever #80 ref_o = ~ref_o;
   end

   // feedback pulse on the active falling edge, half a period late when slipping
   always @(negedge ref_o) begin
      if (slip_i) #80;
      fb_o = 1'b1;
      #40 fb_o = 1'b0;
   end
endmodule : fns_loop_model
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk_i;
   logic        rst_n_i;
   logic [3:0]  avs_address_i;
   logic        avs_read_i;
   logic        avs_write_i;
   logic [31:0] avs_writedata_i;
   logic [3:0]  avs_byteenable_i;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic        ref_w;
   logic        fb_w;
   logic        mux_w;
   logic        lock_w;
   logic        boost_w;
   logic        tris_w;
   logic [3:0]  cur_w;
   logic        lown_w;
   logic        pol_w;
   logic        crst_w;
   logic        pd_w;
   logic        dbl_w;
   logic        dith_w;
   logic        pre_w;
   logic [3:0]  ratio_w;
   logic [8:0]  int_w;
   logic [11:0] fractional_numerator_w;
   logic [11:0] mod_w;
   logic        slip;
   logic [31:0] q;
   int          error_cnt;
   int          checked;

   // ---------------------------------------------------------------
   // design and far side
   // ---------------------------------------------------------------
   fns_regctl DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .reference_input_i(ref_w),
      .rf_feedback_input_i(fb_w), .multiplexed_output_o(mux_w), .lock_detect_o(lock_w),
      .cp_boost_o(boost_w), .cp_tristate_o(tris_w), .cp_current_o(cur_w),
      .cp_low_noise_o(lown_w), .pd_polarity_o(pol_w), .counter_reset_o(crst_w),
      .power_down_o(pd_w), .doubler_en_o(dbl_w), .dither_en_o(dith_w), .prescaler_o(pre_w),
      .ref_ratio_o(ratio_w), .int_o(int_w), .fractional_numerator_o(fractional_numerator_w), .mod_o(mod_w));
   fns_loop_model u_loop (.slip_i(slip), .ref_o(ref_w), .fb_o(fb_w));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : chk

   task automatic complete_run;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run

   // one bus cycle, held until waitrequest low, then field settling time
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk_i);
      avs_address_i    <= a;
      avs_writedata_i  <= d;
      avs_byteenable_i <= be;
      avs_write_i      <= w;
      avs_read_i       <= !w;
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 20);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
      if (n >= 20) chk(32'h0, 32'h1, "no bus answer");
      repeat (3) @(posedge clk_i);
   endtask : bus

   task automatic wr(input logic [31:0] d);
      bus(1'b1, fns_pkg::ADDR_WORD, d, 4'hF);
   endtask : wr

   function automatic logic [31:0] fbw(logic fl, logic [8:0] iv, logic [11:0] fr);
      return {8'h00, fl, iv, fr, fns_pkg::SEL_FB};
   endfunction : fbw

   function automatic logic [31:0] refw(logic lt, logic [2:0] mx, logic [3:0] ra,
                                        logic [11:0] md);
      return {8'h00, lt, mx, 1'b0, 1'b1, ra, md, fns_pkg::SEL_REF};
   endfunction : refw

   function automatic logic [31:0] ctlw(logic db, logic [3:0] cu, logic po, logic lp,
                                        logic pd, logic ts, logic cr);
      return {20'h00000, db, cu, po, lp, pd, ts, cr, fns_pkg::SEL_CTL};
   endfunction : ctlw

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_routing;
      logic [1:0] m;
      chk(32'(dith_w), 32'h1, "dither after reset");
      wr(ctlw(1'b1, 4'hA, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1));
      chk(32'({dbl_w, cur_w, pol_w, tris_w, crst_w, pd_w}), 32'h1AE, "control");
      wr(ctlw(1'b0, 4'h5, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
      chk(32'({dbl_w, cur_w, tris_w, crst_w}), 32'h014, "control clear");
      bus(1'b1, fns_pkg::ADDR_WORD, ctlw(1'b0, 4'hF, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0), 4'h3);
      chk(32'(cur_w), 32'h5, "partial word write");
      wr(refw(1'b0, fns_pkg::MUX_HIGH, 4'hF, 12'h041));
      chk(32'({pre_w, ratio_w, mux_w}), 32'h3F, "reference fields");
      chk(32'(mod_w), 32'h0, "modulus before feedback write");
      bus(1'b0, fns_pkg::ADDR_MOD, 32'h0, 4'hF);
      chk(q, 32'h0041_0000, "pending modulus");
      wr(fbw(1'b0, 9'h08A, 12'h01E));
      chk(32'(int_w), 32'h08A, "feedback integer");
      chk(32'({fractional_numerator_w, mod_w}), 32'h0001E041, "feedback fraction");
      wr(refw(1'b0, fns_pkg::MUX_GND, 4'h1, 12'h041));
      chk(32'({mux_w, ratio_w}), 32'h01, "mux ground");
      wr(refw(1'b0, fns_pkg::MUX_LOW, 4'h1, 12'h041));
      chk(32'(mux_w), 32'h0, "mux low");
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         wr({16'h0000, 5'h00, m[1], 7'h00, m[0], fns_pkg::SEL_NS});
         chk(32'({dith_w, lown_w}), {30'h0, m == fns_pkg::NS_LOWEST_SPUR,
             m == fns_pkg::NS_LOWEST_NOISE}, "noise mode");
      end
      chk(32'(cur_w), 32'h5, "control kept");
      bus(1'b0, 4'hC, 32'h0, 4'hF);
      chk(q, 32'h0, "unmapped read");
   endtask : t_routing

   task automatic t_fastlock;
      int n;
      wr(refw(1'b1, fns_pkg::MUX_FLSW, 4'h1, 12'h005));
      wr(refw(1'b0, fns_pkg::MUX_FLSW, 4'h1, 12'h041));
      wr(fbw(1'b1, 9'h08A, 12'h01E));
      chk(32'({boost_w, mux_w, mod_w}), 32'h2041, "boost with switch");
      n = 0;
      while (boost_w === 1'b1 && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(n >= 70 && n <= 120), 32'h1, "boost length");
      chk(32'(boost_w), 32'h0, "boost off");
   endtask : t_fastlock

   task automatic t_lock(input logic lp);
      int n;
      int need;
      need = lp ? 40 : 24;
      wr(ctlw(1'b0, 4'h5, 1'b1, lp, 1'b0, 1'b0, 1'b0));
      wr(fbw(1'b0, 9'h08A, 12'h01E));
      chk(32'(lock_w), 32'h0, "lock cleared by channel");
      n = 0;
      while (lock_w !== 1'b1 && n < 1500) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(n >= (need - 2) * 20 && n <= need * 20 + 20), 32'h1, "lock time");
   endtask : t_lock

   task automatic t_slip_pd;
      int n;
      slip = 1'b1;
      n = 0;
      while (lock_w === 1'b1 && n < 100) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(lock_w), 32'h0, "lock lost on slip");
      slip = 1'b0;
      t_lock(1'b1);
      wr(ctlw(1'b0, 4'h9, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0));
      chk(32'({pd_w, tris_w, crst_w, lock_w, cur_w}), 32'hE9, "power-down");
      chk(32'(int_w), 32'h08A, "register kept");
      bus(1'b0, fns_pkg::ADDR_STAT, 32'h0, 4'hF);
      chk(32'(q[2]), 32'h1, "power-down status");
      wr(ctlw(1'b0, 4'h5, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0));
      chk(32'({pd_w, tris_w, crst_w}), 32'h0, "power-up");
   endtask : t_slip_pd

   // ---------------------------------------------------------------
   // clock, sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   initial begin
      rst_n_i          = 1'b0;
      avs_address_i    = 4'h0;
      avs_read_i       = 1'b0;
      avs_write_i      = 1'b0;
      avs_writedata_i  = 32'h0;
      avs_byteenable_i = 4'hF;
      slip             = 1'b0;
      error_cnt        = 0;
      checked          = 0;
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      chk(32'(avs_waitrequest_o), 32'h1, "waitrequest at rest");
      t_routing();
      t_fastlock();
      t_lock(1'b0);
      t_slip_pd();
      complete_run();
   end

   initial begin
      #160000;
      error_cnt++;
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
